// >>> include/spsp_pkg.sv
// Constants, register map and mode types for the standalone pin block.
// Assumes a 250 MHz APB clock; the strap arrives already digitised.
// Notes on behaviour
// (R1) Source role: drive external supply switch enable.
// (R2) Retry strap low: never auto-recover from overcurrent.
// (R3) Retry strap high: auto-recover from either overcurrent.
// (R4) Sink role: default-current output on legacy source.
// (R5) Sink role: mid-current output on 1.5A source.
// (R6) Sink role: high-current output on 3.0A source.
// (R7) Open-drain interrupt low while interrupt pending.
// (R8) Sample configuration strap once after reset.
// (R9) Standalone variant: strap gives address and mode.
// (R10) Other variant: strap gives customer value 0-15.
// (R11) Hub pulls overcurrent low; maps to fault event.
// (R12) One sink output at most; none when detached.
package spsp_pkg;
    // Timing
    localparam int CLK_MHZ = 250;
    localparam int STRAP_SETTLE_NS = 1000;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int RETRY_DELAY_US = 10;
    localparam int RETRY_DELAY_CYC = RETRY_DELAY_US * CLK_MHZ;
    localparam int CNT_W = 12;

    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_MASK = 12'h008;
    localparam logic [11:0] OFS_STRAP = 12'h00c;
    localparam logic [11:0] OFS_PORT = 12'h010;

    // Control fields
    localparam int CTRL_SUPPLY_EN = 0;
    localparam int CTRL_RECOVER = 1;
    localparam logic CTRL_SUPPLY_EN_RST = 1'b1;

    // Status and mask fields
    localparam int ST_SW_FAULT = 0;
    localparam int ST_CABLE_FAULT = 1;
    localparam int ST_ATTACH = 2;
    localparam int ST_STRAP = 3;
    localparam int ST_W = 4;
    localparam logic [3:0] MASK_RST = 4'h0;

    // Source current levels from the detection logic
    localparam logic [1:0] LVL_DEFAULT = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // Strap decode: codes 0-7 companion, 8-11 source, 12-15 sink
    localparam logic [3:0] STRAP_SRC_FIRST = 4'h8;
    localparam logic [3:0] STRAP_SNK_FIRST = 4'hc;
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h20;

    typedef enum logic [1:0] {MODE_COMPANION, MODE_SOURCE, MODE_SINK} spsp_mode_e;
endpackage

// >>> core/spsp_port_pins.sv
// Standalone sideband pin logic: supply switch, sink level pins, IRQ, strap.
// APB slave on pclk; overcurrent and retry strap pins are asynchronous.
// Detection and strap converter results come from logic on pclk.
`timescale 1ns/1ps
module spsp_port_pins
    import spsp_pkg::*;
#(
    parameter bit STANDALONE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap converter and attach detection
    input wire logic [3:0] strap_level,
    input wire logic strap_level_valid,
    input wire logic port_attached,
    input wire logic [1:0] source_level,
    input wire logic cable_supply_fault,
    // Source role pins
    input wire logic overcurrent_in_n,
    input wire logic fault_retry_strap,
    output logic external_supply_switch_en,
    // Sink role open-drain pins
    input wire logic sink_default_current_n_i,
    output logic sink_default_current_n_o,
    output logic sink_default_current_n_oe,
    input wire logic sink_mid_current_n_i,
    output logic sink_mid_current_n_o,
    output logic sink_mid_current_n_oe,
    input wire logic sink_high_current_n_i,
    output logic sink_high_current_n_o,
    output logic sink_high_current_n_oe,
    // Open-drain interrupt
    input wire logic irq_n_i,
    output logic irq_n_o,
    output logic irq_n_oe,
    // Strap results
    output logic strap_done,
    output logic [3:0] strap_value,
    output logic [1:0] op_mode,
    output logic [6:0] slave_addr
);

    typedef enum logic [1:0] {S_IDLE, S_POWER, S_RETRY, S_FAULT} spsp_state_e;

    spsp_state_e state, next_state;
    logic [1:0] sync1, sync2;
    logic oc_prev, cable_prev, attach_prev;
    logic [CNT_W-1:0] retry_cnt, next_retry_cnt, settle_cnt;
    logic ctrl_supply_en;
    logic [ST_W-1:0] status, mask;
    spsp_mode_e mode;

    // Strap code to mode; used for the live value and the register view
    function automatic spsp_mode_e strap_mode(input logic [3:0] code);
        if (!STANDALONE_VARIANT || code < STRAP_SRC_FIRST) begin
            strap_mode = MODE_COMPANION;
        end else if (code < STRAP_SNK_FIRST) begin
            strap_mode = MODE_SOURCE;
        end else begin
            strap_mode = MODE_SINK;
        end
    endfunction

    // APB decode
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pready & pwrite;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_status = paddr == OFS_STATUS;
    wire hit_mask = paddr == OFS_MASK;
    wire hit_strap = paddr == OFS_STRAP;
    wire hit_port = paddr == OFS_PORT;
    wire hit_any = hit_ctrl | hit_status | hit_mask | hit_strap | hit_port;
    wire recover_wr = apb_wr & hit_ctrl & pwdata[CTRL_RECOVER];
    wire [ST_W-1:0] clear_w1c = (apb_wr & hit_status) ? pwdata[ST_W-1:0] : '0;

    // Pin-derived levels, read only from the second sync stage
    wire oc_active = ~sync2[0];
    wire retry_en = sync2[1];
    wire src_mode = strap_done & (mode == MODE_SOURCE);
    wire snk_mode = strap_done & (mode == MODE_SINK);
    wire fault_lvl = oc_active | cable_supply_fault;

    // Events feeding the sticky status bits
    wire ev_sw_fault = src_mode & oc_active & ~oc_prev; // [R11]
    wire ev_cable = src_mode & cable_supply_fault & ~cable_prev;
    wire ev_attach = port_attached ^ attach_prev;
    wire ev_strap = ~strap_done & (settle_cnt == '0) & strap_level_valid;
    wire [ST_W-1:0] events = {ev_strap, ev_attach, ev_cable, ev_sw_fault};
    // Set wins over a clear in the same cycle
    wire [ST_W-1:0] next_status = (status & ~clear_w1c) | events;
    wire irq_pending = |(status & mask);

    // Sink level decode, gated by role and attach
    wire sink_live = snk_mode & port_attached; // [R12]
    wire next_snk_def = sink_live & (source_level == LVL_DEFAULT); // [R4]
    wire next_snk_mid = sink_live & (source_level == LVL_MID); // [R5]
    wire next_snk_high = sink_live & (source_level == LVL_HIGH); // [R6]

    // Read mux
    wire [31:0] rd_ctrl = {31'h0, ctrl_supply_en};
    wire [31:0] rd_status = {28'h0, status};
    wire [31:0] rd_mask = {28'h0, mask};
    wire [31:0] rd_strap = {17'h0, slave_addr, op_mode, strap_value, 1'h0, strap_done};
    wire [31:0] rd_port = {24'h0, state, retry_en, oc_active, source_level,
                           external_supply_switch_en, port_attached};
    wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
                          hit_status ? rd_status :
                          hit_mask ? rd_mask :
                          hit_strap ? rd_strap :
                          hit_port ? rd_port : 32'h0;

    // Connector state machine for the source role
    always_comb begin
        next_state = state;
        next_retry_cnt = retry_cnt;
        case (state)
            S_IDLE: begin
                if (src_mode & port_attached & ctrl_supply_en & ~fault_lvl) begin
                    next_state = S_POWER;
                end
            end
            S_POWER: begin
                if (fault_lvl) begin
                    next_state = retry_en ? S_RETRY : S_FAULT; // [R2] [R3]
                    next_retry_cnt = CNT_W'(RETRY_DELAY_CYC - 1);
                end else if (~src_mode | ~port_attached | ~ctrl_supply_en) begin
                    next_state = S_IDLE;
                end
            end
            S_RETRY: begin
                // A fault still present restarts the wait
                if (fault_lvl) begin
                    next_retry_cnt = CNT_W'(RETRY_DELAY_CYC - 1);
                end else if (retry_cnt != '0) begin
                    next_retry_cnt = retry_cnt - CNT_W'(1);
                end else begin
                    next_state = S_IDLE; // [R3]
                end
            end
            S_FAULT: begin
                // Only software brings the port back
                if (recover_wr) begin
                    next_state = S_IDLE; // [R2]
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    // State, counter and supply enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            retry_cnt <= '0;
            external_supply_switch_en <= 1'b0;
        end else begin
            state <= next_state;
            retry_cnt <= next_retry_cnt;
            external_supply_switch_en <= next_state == S_POWER; // [R1]
        end
    end

    // Two-flop synchronisers for the asynchronous pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 2'h1;
            sync2 <= 2'h1;
        end else begin
            sync1 <= {fault_retry_strap, overcurrent_in_n};
            sync2 <= sync1;
        end
    end

    // Edge history for event detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_prev <= 1'b0;
            cable_prev <= 1'b0;
            attach_prev <= 1'b0;
        end else begin
            oc_prev <= oc_active;
            cable_prev <= cable_supply_fault;
            attach_prev <= port_attached;
        end
    end

    // Strap capture: one sample after the settle time, never again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= CNT_W'(STRAP_SETTLE_CYC - 1);
            strap_done <= 1'b0;
            strap_value <= 4'h0;
            mode <= MODE_COMPANION;
            op_mode <= 2'h0;
            slave_addr <= SLAVE_ADDR_BASE;
        end else if (settle_cnt != '0) begin
            settle_cnt <= settle_cnt - CNT_W'(1);
        end else if (ev_strap) begin
            strap_done <= 1'b1; // [R8]
            strap_value <= strap_level; // [R10]
            mode <= strap_mode(strap_level); // [R9]
            op_mode <= strap_mode(strap_level);
            slave_addr <= SLAVE_ADDR_BASE + {5'h0, strap_level[1:0]}; // [R9]
        end
    end

    // Registers, sink pins and interrupt pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_supply_en <= CTRL_SUPPLY_EN_RST;
            mask <= MASK_RST;
            status <= '0;
            sink_default_current_n_oe <= 1'b0;
            sink_mid_current_n_oe <= 1'b0;
            sink_high_current_n_oe <= 1'b0;
            irq_n_oe <= 1'b0;
        end else begin
            if (apb_wr & hit_ctrl) begin
                ctrl_supply_en <= pwdata[CTRL_SUPPLY_EN];
            end
            if (apb_wr & hit_mask) begin
                mask <= pwdata[ST_W-1:0];
            end
            status <= next_status;
            sink_default_current_n_oe <= next_snk_def; // [R4]
            sink_mid_current_n_oe <= next_snk_mid; // [R5]
            sink_high_current_n_oe <= next_snk_high; // [R6]
            irq_n_oe <= irq_pending; // [R7]
        end
    end

    // Open-drain pins only ever pull low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sink_default_current_n_o <= 1'b0;
            sink_mid_current_n_o <= 1'b0;
            sink_high_current_n_o <= 1'b0;
            irq_n_o <= 1'b0;
        end else begin
            sink_default_current_n_o <= 1'b0;
            sink_mid_current_n_o <= 1'b0;
            sink_high_current_n_o <= 1'b0;
            irq_n_o <= 1'b0;
        end
    end

    // APB answer: one access cycle, data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~hit_any;
            prdata <= apb_setup & ~pwrite ? rd_data : 32'h0;
        end
    end

    a_supply_on_power: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        state == S_POWER && $past(state) == S_IDLE |-> external_supply_switch_en)
        else $error("supply enable not driven in power state");
    a_no_auto_recover: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        state == S_FAULT && !recover_wr |=> state == S_FAULT && !external_supply_switch_en)
        else $error("left fault state without software");
    a_retry_leaves: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        state == S_RETRY && retry_cnt == '0 && !fault_lvl |=> state == S_IDLE)
        else $error("retry wait did not end");
    a_sink_default: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        snk_mode && port_attached && source_level == LVL_DEFAULT
        |=> sink_default_current_n_oe && !sink_default_current_n_o)
        else $error("default-current pin not pulled");
    a_sink_mid: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        snk_mode && port_attached && source_level == LVL_MID |=> sink_mid_current_n_oe)
        else $error("mid-current pin not pulled");
    a_sink_high: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        snk_mode && port_attached && source_level == LVL_HIGH |=> sink_high_current_n_oe)
        else $error("high-current pin not pulled");
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        irq_pending |=> irq_n_oe ##0 !irq_n_o)
        else $error("interrupt not signalled");
    a_strap_frozen: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        strap_done |=> strap_done && $stable(strap_value) && $stable(slave_addr))
        else $error("strap resampled");
    a_hub_fault_sets: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        ev_sw_fault |=> status[ST_SW_FAULT])
        else $error("hub overcurrent not flagged");
    a_sink_exclusive: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        $onehot0({sink_default_current_n_oe, sink_mid_current_n_oe, sink_high_current_n_oe}))
        else $error("sink outputs overlap");
    a_sink_detached: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        !port_attached |=> !(sink_default_current_n_oe | sink_mid_current_n_oe
        | sink_high_current_n_oe))
        else $error("sink output held while detached");

endmodule

// >>> verification/spsp_hub_model.sv
// Far side model: partner hub overcurrent line and the board pull-ups.
// Assumes the testbench asks for a fault through oc_req on pclk.
`timescale 1ns/1ps
module spsp_hub_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Testbench request
    input wire logic oc_req,
    // Hub overcurrent line
    output logic overcurrent_in_n,
    // Open-drain pins: irq, high, mid, default
    input wire logic [3:0] od_oe,
    input wire logic [3:0] od_o,
    output logic [3:0] od_pin
);
    // Hub pulls the line low to report a fault, pull-up idles it high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overcurrent_in_n <= 1'b1;
        end else begin
            overcurrent_in_n <= !oc_req;
        end
    end

    // Weak pull-ups: a released pin reads high, a driven pin shows the drive
    assign od_pin = ~od_oe | od_o;
endmodule

// >>> verification/test_standalone_port_status_pins.sv
// Testbench for the standalone pin block: sink pins, supply, irq, strap.
// Assumes a 250 MHz pclk and an APB master driven from this module.
`timescale 1ns/1ps
module test_standalone_port_status_pins;
    import spsp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] strap_level, strap_value, pin;
    logic strap_level_valid, port_attached, cable_supply_fault, oc_req, oc_n;
    logic retry, en, done, d_oe, m_oe, h_oe, i_oe, d_o, m_o, h_o, i_o;
    logic [1:0] source_level, op_mode;
    logic [6:0] slave_addr;
    logic [2:0] want [$] = '{3'b110, 3'b101, 3'b011, 3'b111, 3'b111};
    int failures = 0, total_checks = 0, seed = 66295, n, code, m;

    spsp_port_pins i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strap_level(strap_level),
        .strap_level_valid(strap_level_valid), .port_attached(port_attached),
        .source_level(source_level), .cable_supply_fault(cable_supply_fault),
        .overcurrent_in_n(oc_n), .fault_retry_strap(retry),
        .external_supply_switch_en(en), .sink_default_current_n_i(pin[0]),
        .sink_default_current_n_o(d_o), .sink_default_current_n_oe(d_oe),
        .sink_mid_current_n_i(pin[1]), .sink_mid_current_n_o(m_o),
        .sink_mid_current_n_oe(m_oe), .sink_high_current_n_i(pin[2]),
        .sink_high_current_n_o(h_o), .sink_high_current_n_oe(h_oe),
        .irq_n_i(pin[3]), .irq_n_o(i_o), .irq_n_oe(i_oe), .strap_done(done),
        .strap_value(strap_value), .op_mode(op_mode), .slave_addr(slave_addr));

    spsp_hub_model i_hub (.pclk(pclk), .presetn(presetn), .oc_req(oc_req),
        .overcurrent_in_n(oc_n), .od_oe({i_oe, h_oe, m_oe, d_oe}),
        .od_o({i_o, h_o, m_o, d_o}), .od_pin(pin));

    // Free running bus clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; waits on pready rather than assuming a latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Bounded wait for the supply enable; n keeps the cycles spent
    task automatic wait_en(input logic v, input int lim);
        n = 0;
        while (en !== v && n < lim) begin
            n++;
            @(posedge pclk);
        end
        chk("supply_en", v, en);
    endtask

    // Reset with a strap code, then check what was captured
    task automatic boot(input int c);
        m = c < 8 ? 0 : c < 12 ? 1 : 2;
        presetn <= 1'b0;
        port_attached <= 1'b0;
        strap_level <= ~c[3:0];
        strap_level_valid <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("reset_addr", 32'h20, slave_addr);
        presetn <= 1'b1;
        // Converter result not valid yet past the settle time: a wrong code shows
        repeat (260) @(posedge pclk);
        strap_level <= c[3:0];
        strap_level_valid <= 1'b1;
        repeat (40) @(posedge pclk);
        strap_level <= ~c[3:0];
        repeat (3) @(posedge pclk);
        chk("strap_done", 1, done);
        chk("strap_value", c, strap_value);
        chk("op_mode", m, op_mode);
        chk("slave_addr", 32 + c % 4, slave_addr);
        apb(1'b0, OFS_STRAP, 32'h0);
        chk("strap_reg", ((32 + c % 4) << 8) | (m << 6) | (c << 2) | 1, rd);
        chk("irq_masked", 1, pin[3]);
    endtask

    task complete_run;
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog well beyond the roughly 6500 cycles of the sequence
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        complete_run;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {strap_level, port_attached, cable_supply_fault, oc_req, retry} = '0;
        strap_level_valid = 1'b1;
        source_level = 2'h3;
        @(posedge pclk);
        // Sink role: walk every level, then detach
        boot(12 + $unsigned($random(seed)) % 4);
        port_attached <= 1'b1;
        for (int l = 0; l < 5; l++) begin
            source_level <= l[1:0];
            if (l == 4) port_attached <= 1'b0;
            repeat (3) @(posedge pclk);
            chk("sink_pins", want[l], pin[2:0]);
        end
        // Source role, no automatic retry
        boot(8 + $unsigned($random(seed)) % 4);
        apb(1'b1, OFS_MASK, 32'h3);
        port_attached <= 1'b1;
        wait_en(1'b1, 20);
        oc_req <= 1'b1;
        wait_en(1'b0, 20);
        repeat (2) @(posedge pclk);
        chk("irq_pin", 0, pin[3]);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status_oc", 1, rd[0]);
        oc_req <= 1'b0;
        repeat (3000) @(posedge pclk);
        chk("no_retry", 0, en);
        apb(1'b1, OFS_STATUS, 32'hf);
        repeat (3) @(posedge pclk);
        chk("irq_pin", 1, pin[3]);
        apb(1'b1, OFS_CTRL, 32'h3);
        wait_en(1'b1, 20);
        // Retry strap high: cable fault recovers on its own
        retry <= 1'b1;
        // Strap passes two sync stages before the fault may see it
        repeat (3) @(posedge pclk);
        cable_supply_fault <= 1'b1;
        wait_en(1'b0, 20);
        cable_supply_fault <= 1'b0;
        wait_en(1'b1, 2700);
        chk("retry_wait", 1, n >= 2490);
        // Unmapped address is refused
        apb(1'b0, 12'h014, 32'h0);
        chk("slverr", 1, err);
        chk("unmapped_rd", 0, rd);
        // Companion codes: no supply, no sink pins even when attached
        boot($unsigned($random(seed)) % 8);
        port_attached <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("companion_en", 0, en);
        chk("companion_pins", 4'hf, pin);
        complete_run;
    end
endmodule
